// file: verilog/mcrb_top.sv
// Metering control register bank: APB slave holding converter, battery and engine controls.
// Assumes an APB master on pclk and analogue and engine logic outside this block.
//
// Notes on behaviour
// (RULE1) Converter enable powers converter; reset zero.
// (RULE2) Converter clock master over four or eight.
// (RULE3) Converter rates follow master clock and divider.
// (RULE4) Battery load enable connects test load.
// (RULE5) Battery result read only, no reset.
// (RULE6) Engine program base is 1024 times location.
// (RULE7) Engine enable runs engine; clear holds stopped.
//
// Our own choice: register access over APB.
`timescale 1ns/1ps
module mcrb_top (
  // Clock and reset.
  input  wire logic                                  pclk,
  input  wire logic                                  presetn,
  // APB slave.
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [mcrb_pkg::ADDR_W-1:0]           paddr,
  input  wire logic [31:0]                           pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic      [31:0]                           prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // Analogue controls.
  output logic                                       converter_enable,
  output logic                                       converter_clock,
  output logic                                       battery_load_enable,
  output logic                                       battery_select,
  // Battery measurement from the analogue side.
  input  wire logic [mcrb_pkg::RESULT_W-1:0]         battery_measurement_in,
  // Computation engine.
  output logic                                       engine_run,
  output logic [mcrb_pkg::LOC_W+mcrb_pkg::LOC_SHIFT-1:0] engine_program_base
);

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode.

  // True when the byte address selects the word at the given index.
  function automatic logic hit(input logic [15:0] addr, input logic [15:0] idx);
    hit = (addr == {idx[13:0], 2'b00});
  endfunction

  // True when the byte address selects any word of this bank.
  function automatic logic mapped(input logic [15:0] addr);
    mapped = hit(addr, mcrb_pkg::IDX_ENGINE_CTRL) || hit(addr, mcrb_pkg::IDX_ENGINE_LOC)
          || hit(addr, mcrb_pkg::IDX_CONV_CLOCK)  || hit(addr, mcrb_pkg::IDX_ANALOG_CTRL)
          || hit(addr, mcrb_pkg::IDX_BATT_RESULT) || hit(addr, mcrb_pkg::IDX_BATT_SELECT);
  endfunction

  mcrb_div_if div_link (); // Link to the converter clock divider.

  logic                          setup;        // APB setup phase.
  logic                          wr;           // Write taken in this access cycle.
  logic                          eng_en;       // Engine enable.
  logic                          next_eng_en;
  logic [mcrb_pkg::LOC_W-1:0]    loc;          // Engine program location.
  logic [mcrb_pkg::LOC_W-1:0]    next_loc;
  logic                          div_sel;      // Converter clock divide select.
  logic                          next_div_sel;
  logic                          conv_en;      // Converter enable.
  logic                          next_conv_en;
  logic                          batt_load;    // Battery test load enable.
  logic                          next_batt_load;
  logic                          batt_sel;     // Battery select.
  logic                          next_batt_sel;
  logic [31:0]                   rdata;        // Registered read data.
  logic [31:0]                   next_rdata;
  logic                          err;          // Registered error answer.
  logic                          next_err;
  logic [mcrb_pkg::RESULT_W-1:0] meas_s1;      // First synchroniser stage.
  logic [mcrb_pkg::RESULT_W-1:0] meas_s2;      // Second synchroniser stage.

  // Setup captures read data; the access cycle always completes at once.
  assign setup  = psel && !penable;
  assign wr     = psel && penable && pwrite && pstrb[0];
  assign pready = psel && penable;

  ////////////////////////////////////////////////////////////////////////////////
  // Battery measurement enters from the analogue domain through two flops.
  // It has no defined reset value, so these flops take none.
  always_ff @(posedge pclk) begin
    meas_s1 <= battery_measurement_in; // RULE5
    meas_s2 <= meas_s1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next register values: writes land on the access edge, reads are built in setup.
  always_comb begin
    next_eng_en    = eng_en;
    next_loc       = loc;
    next_div_sel   = div_sel;
    next_conv_en   = conv_en;
    next_batt_load = batt_load;
    next_batt_sel  = batt_sel;
    next_rdata     = rdata;
    next_err       = err;
    if (setup) begin
      // Build the answer one cycle early so that prdata comes from a flop.
      next_err   = !mapped(paddr);
      next_rdata = 32'h0000_0000;
      if (hit(paddr, mcrb_pkg::IDX_ENGINE_CTRL)) begin
        next_rdata[mcrb_pkg::ENGINE_ENABLE_BIT] = eng_en;
      end else if (hit(paddr, mcrb_pkg::IDX_ENGINE_LOC)) begin
        next_rdata[mcrb_pkg::LOC_W-1:0] = loc;
      end else if (hit(paddr, mcrb_pkg::IDX_CONV_CLOCK)) begin
        next_rdata[mcrb_pkg::CONV_DIV_BIT] = div_sel;
      end else if (hit(paddr, mcrb_pkg::IDX_ANALOG_CTRL)) begin
        next_rdata[mcrb_pkg::CONV_ENABLE_BIT] = conv_en;
        next_rdata[mcrb_pkg::BATT_LOAD_BIT]   = batt_load;
      end else if (hit(paddr, mcrb_pkg::IDX_BATT_RESULT)) begin
        next_rdata[mcrb_pkg::RESULT_W-1:0] = meas_s2; // RULE5
      end else if (hit(paddr, mcrb_pkg::IDX_BATT_SELECT)) begin
        next_rdata[mcrb_pkg::BATT_SELECT_BIT] = batt_sel;
      end else begin
        // Unmapped address reads as zero and answers with an error.
        next_rdata = 32'h0000_0000;
      end
    end
    if (wr) begin
      // Only byte lane zero carries fields; the result word ignores writes.
      if (hit(paddr, mcrb_pkg::IDX_ENGINE_CTRL)) begin
        next_eng_en = pwdata[mcrb_pkg::ENGINE_ENABLE_BIT]; // RULE7
      end
      if (hit(paddr, mcrb_pkg::IDX_ENGINE_LOC)) begin
        next_loc = pwdata[mcrb_pkg::LOC_W-1:0]; // RULE6
      end
      if (hit(paddr, mcrb_pkg::IDX_CONV_CLOCK)) begin
        next_div_sel = pwdata[mcrb_pkg::CONV_DIV_BIT]; // RULE2
      end
      if (hit(paddr, mcrb_pkg::IDX_ANALOG_CTRL)) begin
        next_conv_en   = pwdata[mcrb_pkg::CONV_ENABLE_BIT]; // RULE1
        next_batt_load = pwdata[mcrb_pkg::BATT_LOAD_BIT];   // RULE4
      end
      if (hit(paddr, mcrb_pkg::IDX_BATT_SELECT)) begin
        next_batt_sel = pwdata[mcrb_pkg::BATT_SELECT_BIT]; // RULE4
      end
    end
  end

  // Register the bank; reset loads the documented values.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eng_en    <= mcrb_pkg::BIT_RST;
      loc       <= mcrb_pkg::LOC_RST; // RULE6
      div_sel   <= mcrb_pkg::BIT_RST;
      conv_en   <= mcrb_pkg::BIT_RST;
      batt_load <= mcrb_pkg::BIT_RST;
      batt_sel  <= mcrb_pkg::BIT_RST;
      rdata     <= 32'h0000_0000;
      err       <= 1'b0;
    end else begin
      eng_en    <= next_eng_en;
      loc       <= next_loc;
      div_sel   <= next_div_sel;
      conv_en   <= next_conv_en;
      batt_load <= next_batt_load;
      batt_sel  <= next_batt_sel;
      rdata     <= next_rdata;
      err       <= next_err;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs and the converter clock divider.

  assign prdata              = rdata;
  assign pslverr             = err && psel && penable;
  assign converter_enable    = conv_en; // RULE1
  assign battery_load_enable = batt_load; // RULE4
  assign battery_select      = batt_sel;
  assign engine_run          = eng_en; // RULE7
  assign engine_program_base = {loc, {mcrb_pkg::LOC_SHIFT{1'b0}}}; // RULE6

  // The divider runs only while the converter is powered.
  assign div_link.enable  = conv_en;
  assign div_link.div_sel = div_sel;
  assign converter_clock  = div_link.conv_clk; // RULE3

  mcrb_clk_div #(
    .PLL_FAST (1'b1)
  ) u_clk_div (
    .pclk    (pclk),
    .presetn (presetn),
    .link    (div_link)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on the bank.
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_conv_enable_write: assert property ( // RULE1
    (wr && hit(paddr, mcrb_pkg::IDX_ANALOG_CTRL))
    |=> converter_enable == $past(pwdata[mcrb_pkg::CONV_ENABLE_BIT]))
    else $error("converter enable did not follow its write");

  a_div_select_write: assert property ( // RULE2
    (wr && hit(paddr, mcrb_pkg::IDX_CONV_CLOCK))
    |=> div_link.div_sel == $past(pwdata[mcrb_pkg::CONV_DIV_BIT]))
    else $error("divide select did not follow its write");

  a_batt_load_write: assert property ( // RULE4
    (wr && hit(paddr, mcrb_pkg::IDX_ANALOG_CTRL))
    |=> battery_load_enable == $past(pwdata[mcrb_pkg::BATT_LOAD_BIT]) && $stable(battery_select))
    else $error("battery load enable did not follow its write");

  a_result_read: assert property ( // RULE5
    (setup && !pwrite && hit(paddr, mcrb_pkg::IDX_BATT_RESULT)) ##1 (psel && penable)
    |-> prdata == {24'h00_0000, $past(meas_s2)})
    else $error("battery result read returned the wrong value");

  a_program_base: assert property ( // RULE6
    (wr && hit(paddr, mcrb_pkg::IDX_ENGINE_LOC))
    |=> engine_program_base == {$past(pwdata[mcrb_pkg::LOC_W-1:0]), 10'h000})
    else $error("engine program base is not 1024 times the location");

  a_engine_stop: assert property ( // RULE7
    (wr && hit(paddr, mcrb_pkg::IDX_ENGINE_CTRL) && !pwdata[mcrb_pkg::ENGINE_ENABLE_BIT])
    |=> !engine_run throughout (!wr)[*1])
    else $error("engine still runs after its enable was cleared");

  a_unmapped_error: assert property (
    (setup && !mapped(paddr)) ##1 (psel && penable) |-> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access did not answer with an error");

endmodule

// file: common/mcrb_pkg.sv
// Shared constants for the metering control register bank.
// Assumes a 32-bit APB slave whose byte address is four times the register index.
package mcrb_pkg;

  // Width of the APB byte address.
  localparam int ADDR_W = 16;

  // Register indices; the byte address is four times each index.
  localparam logic [15:0] IDX_ENGINE_CTRL = 16'h2106; // Engine enable.
  localparam logic [15:0] IDX_ENGINE_LOC  = 16'h2109; // Engine program location.
  localparam logic [15:0] IDX_CONV_CLOCK  = 16'h2200; // Converter clock divide.
  localparam logic [15:0] IDX_ANALOG_CTRL = 16'h2704; // Converter enable and battery load.
  localparam logic [15:0] IDX_BATT_RESULT = 16'h2885; // Battery measurement, read only.
  localparam logic [15:0] IDX_BATT_SELECT = 16'h2F00; // Battery select.

  // Field positions inside the low byte of each word.
  localparam int ENGINE_ENABLE_BIT = 0;
  localparam int CONV_DIV_BIT      = 5;
  localparam int CONV_ENABLE_BIT   = 4;
  localparam int BATT_LOAD_BIT     = 3;
  localparam int BATT_SELECT_BIT   = 0;
  localparam int LOC_W             = 7;
  localparam int RESULT_W          = 8;

  // Program location step is 1024 bytes, a shift of ten.
  localparam int LOC_SHIFT = 10;

  // Reset values.
  localparam logic [6:0] LOC_RST = 7'h1f;
  localparam logic       BIT_RST = 1'h0;

  // Master clock divide ratios for the converter and filter clock.
  localparam logic [3:0] DIV_BY_LOW  = 4'h4;
  localparam logic [3:0] DIV_BY_HIGH = 4'h8;

  // Master clock and resulting converter clock rates in hertz.
  localparam int MCK_SLOW_HZ       = 32'h0060_0000;
  localparam int MCK_FAST_HZ       = 32'h012C_0000;
  localparam int CONV_SLOW_DIV4_HZ = 32'h0018_0000;
  localparam int CONV_SLOW_DIV8_HZ = 32'h000C_0000;
  localparam int CONV_FAST_DIV4_HZ = 32'h004B_0000;
  localparam int CONV_FAST_DIV8_HZ = 32'h0025_8000;

endpackage

// file: common/mcrb_div_if.sv
// Link between the register bank and its converter clock divider.
// Assumes both ends run on the same master clock.
`timescale 1ns/1ps
interface mcrb_div_if;
  logic enable;   // Converter powered; divider runs.
  logic div_sel;  // Zero divides by four, one by eight.
  logic conv_clk; // Divided converter and filter clock.

  modport ctl (output enable, output div_sel, input conv_clk);
  modport div (input enable, input div_sel, output conv_clk);
endinterface

// file: verilog/mcrb_clk_div.sv
// Converter and filter clock divider fed by the master clock.
// Assumes enable and div_sel come from flops on the same clock.
`timescale 1ns/1ps
module mcrb_clk_div #(
  parameter bit PLL_FAST = 1'b1
) (
  // Clock and reset.
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Control from the register bank.
  mcrb_div_if.div     link
);

  // Cycles between rising edges expected at divide by eight, from the rate table.
  localparam int PERIOD_HIGH = PLL_FAST ? (mcrb_pkg::MCK_FAST_HZ / mcrb_pkg::CONV_FAST_DIV8_HZ)
                                        : (mcrb_pkg::MCK_SLOW_HZ / mcrb_pkg::CONV_SLOW_DIV8_HZ);

  logic [2:0] cnt;           // Cycles since the last toggle.
  logic [2:0] next_cnt;      // Next cycle count.
  logic       clk_q;         // Registered converter clock.
  logic       next_clk_q;    // Next converter clock.
  logic       prev_sel;      // Divide select seen last cycle.
  logic       next_prev_sel; // Next copy of the divide select.
  logic [2:0] half;          // Cycles per half period.
  logic       prev_clk;      // Helper copy for period checking.
  logic [3:0] since_rise;    // Helper count of cycles since a rising edge.
  logic [3:0] next_since_rise; // Next helper count.

  ////////////////////////////////////////////////////////////////////////////////
  // Divider: toggles every half period, parks low while the converter is idle.
  always_comb begin
    half          = link.div_sel ? mcrb_pkg::DIV_BY_HIGH[3:1] : mcrb_pkg::DIV_BY_LOW[3:1]; // RULE2
    next_cnt      = cnt;
    next_clk_q    = clk_q;
    next_prev_sel = link.div_sel;
    if (!link.enable) begin
      // Idle converter gets no clock.
      next_cnt   = 3'h0; // RULE1
      next_clk_q = 1'b0;
    end else if (link.div_sel != prev_sel) begin
      // Restart from low so the new ratio begins with a full low half period.
      next_cnt   = 3'h0;
      next_clk_q = 1'b0;
    end else if (cnt == half - 3'h1) begin
      // Half period complete.
      next_cnt   = 3'h0;
      next_clk_q = ~clk_q; // RULE2
    end else begin
      // Keep counting.
      next_cnt = cnt + 3'h1;
    end
  end

  // Register the divider state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 3'h0;
      clk_q    <= 1'b0;
      prev_sel <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      clk_q    <= next_clk_q;
      prev_sel <= next_prev_sel;
    end
  end

  assign link.conv_clk = clk_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper for the period checks below: restarts on a rise and saturates at fifteen.
  always_comb begin
    next_since_rise = since_rise + {3'h0, (since_rise != 4'hf)};
    if (clk_q && !prev_clk) begin
      // A new rising edge starts the count again.
      next_since_rise = 4'h1;
    end
  end

  // Register the helper state.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_clk   <= 1'b0;
      since_rise <= 4'h0;
    end else begin
      prev_clk   <= clk_q;
      since_rise <= next_since_rise;
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_idle_no_clock: assert property ( // RULE1
    !link.enable |=> !link.conv_clk)
    else $error("converter clock runs while the converter is idle");

  a_div_low_rate: assert property ( // RULE2
    ($changed(link.conv_clk) && link.enable && !link.div_sel)
      ##1 (link.enable && !link.div_sel)[*2]
    |-> $changed(link.conv_clk) && ($past(link.conv_clk, 1) == $past(link.conv_clk, 2)))
    else $error("divide by four does not toggle every two cycles");

  a_div_high_period: assert property ( // RULE3
    ($rose(link.conv_clk) && link.enable && link.div_sel)
      ##1 (link.enable && link.div_sel)[*7]
    |=> $rose(link.conv_clk) && (since_rise == PERIOD_HIGH[3:0]))
    else $error("divide by eight period does not match the rate table");

endmodule

// file: tb/mcrb_top_tb.sv
// Self-checking bench for the metering control register bank, driven over APB.
// Assumes pclk stands for the master clock at the fast PLL setting.
`timescale 1ns/1ps
module mcrb_top_tb;
  // Clock, reset and APB drive.
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [7:0]  batt_in;
  // Design outputs.
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        conv_en;
  logic        conv_clk;
  logic        load_en;
  logic        batt_sel;
  logic        eng_run;
  logic [16:0] eng_base;
  // Bench bookkeeping.
  int          err_count;
  int          n_compared;
  int          cycles = 0;
  bit          held;
  logic [31:0] rv;
  logic        ev;
  int          per;
  int          hi;

  // Byte addresses, four times each register index.
  localparam logic [15:0] A_ENG = mcrb_pkg::IDX_ENGINE_CTRL << 2;
  localparam logic [15:0] A_LOC = mcrb_pkg::IDX_ENGINE_LOC << 2;
  localparam logic [15:0] A_DIV = mcrb_pkg::IDX_CONV_CLOCK << 2;
  localparam logic [15:0] A_ANA = mcrb_pkg::IDX_ANALOG_CTRL << 2;
  localparam logic [15:0] A_RES = mcrb_pkg::IDX_BATT_RESULT << 2;
  localparam logic [15:0] A_SEL = mcrb_pkg::IDX_BATT_SELECT << 2;

  mcrb_top mcrb_top_i (
    .pclk                   (pclk),
    .presetn                (presetn),
    .psel                   (psel),
    .penable                (penable),
    .pwrite                 (pwrite),
    .paddr                  (paddr),
    .pwdata                 (pwdata),
    .pstrb                  (pstrb),
    .prdata                 (prdata),
    .pready                 (pready),
    .pslverr                (pslverr),
    .converter_enable       (conv_en),
    .converter_clock        (conv_clk),
    .battery_load_enable    (load_en),
    .battery_select         (batt_sel),
    .battery_measurement_in (batt_in),
    .engine_run             (eng_run),
    .engine_program_base    (eng_base)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 5 ns and a cycle ceiling that cuts a hang short.
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counts and prints the verdict, then ends the run.
  task automatic stop_test();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Compares one value with case equality and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // One APB transfer; keep leaves psel up so the next setup follows at once.
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, input bit keep,
                     output logic [31:0] rdv, output logic errv);
    if (!held) begin
      @(posedge pclk);
    end
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for pready sampled high; only the cycle ceiling ends a hang.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv  = prdata;
    errv = pslverr;
    held = keep;
    if (!keep) begin
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // Full-strobe write that expects no error.
  task automatic wr_reg(input logic [15:0] a, input logic [31:0] d, input bit keep = 0);
    apb(1'b1, a, d, 4'hf, keep, rv, ev);
    chk_bit(ev, 1'b0);
  endtask

  // Read whose masked data must match and that expects no error.
  task automatic rd(input logic [15:0] a, input logic [31:0] m, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0, 1'b0, rv, ev);
    chk(rv & m, exp);
    chk_bit(ev, 1'b0);
  endtask

  // Lets register outputs land one cycle after the write edge.
  task automatic settle();
    @(posedge pclk);
    #1;
  endtask

  // Measures converter clock period and high time in pclk cycles.
  task automatic conv_period(output int p, output int h);
    int   n;
    logic prev;
    p    = 0;
    h    = 0;
    prev = 1'b1;
    for (n = 0; n < 40; n++) begin
      settle();
      if (prev === 1'b0 && conv_clk === 1'b1) begin
        break;
      end
      prev = conv_clk;
    end
    prev = 1'b1;
    for (n = 0; n < 40; n++) begin
      if (conv_clk === 1'b1) begin
        h++;
      end
      settle();
      p++;
      if (prev === 1'b0 && conv_clk === 1'b1) begin
        break;
      end
      prev = conv_clk;
    end
  endtask

  // Checks the output levels that reset must give.
  task automatic chk_reset_outs();
    chk_bit(conv_en, 1'b0);
    chk_bit(conv_clk, 1'b0);
    chk_bit(load_en, 1'b0);
    chk_bit(batt_sel, 1'b0);
    chk_bit(eng_run, 1'b0);
    chk({15'h0, eng_base}, 32'h0000_7c00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence of tests.
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 16'h0000;
    pwdata  = 32'h0000_0000;
    pstrb   = 4'h0;
    batt_in = 8'h00;
    held    = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    settle();
    // Reset values at the ports and in the registers.
    chk_reset_outs();
    rd(A_ENG, 32'h0000_0001, 32'h0000_0000);
    rd(A_LOC, 32'h0000_007f, 32'h0000_001f);
    rd(A_DIV, 32'h0000_0020, 32'h0000_0000);
    rd(A_ANA, 32'h0000_0018, 32'h0000_0000);
    $display("test reset done");
    // Converter enable and both divide ratios.
    wr_reg(A_ANA, 32'h0000_0010);
    settle();
    chk_bit(conv_en, 1'b1);
    chk_bit(load_en, 1'b0);
    conv_period(per, hi);
    chk(per, mcrb_pkg::MCK_FAST_HZ / mcrb_pkg::CONV_FAST_DIV4_HZ);
    chk(hi, 2);
    wr_reg(A_DIV, 32'h0000_0020);
    conv_period(per, hi);
    conv_period(per, hi);
    chk(per, mcrb_pkg::MCK_FAST_HZ / mcrb_pkg::CONV_FAST_DIV8_HZ);
    chk(hi, 4);
    rd(A_DIV, 32'h0000_0020, 32'h0000_0020);
    // Converter off, test load on; the divided clock must stop low.
    wr_reg(A_ANA, 32'h0000_0008);
    wr_reg(A_SEL, 32'h0000_0001);
    repeat (4) settle();
    chk_bit(conv_en, 1'b0);
    chk_bit(conv_clk, 1'b0);
    chk_bit(load_en, 1'b1);
    chk_bit(batt_sel, 1'b1);
    rd(A_ANA, 32'h0000_0018, 32'h0000_0008);
    $display("test converter done");
    // Engine enable, masked and unmapped writes that must not land.
    wr_reg(A_ENG, 32'h0000_0001);
    settle();
    chk_bit(eng_run, 1'b1);
    apb(1'b1, A_ENG, 32'h0000_0000, 4'h0, 1'b0, rv, ev);
    chk_bit(ev, 1'b0);
    apb(1'b1, A_ENG - 16'h0004, 32'h0000_00ff, 4'hf, 1'b0, rv, ev);
    chk_bit(ev, 1'b1);
    settle();
    chk_bit(eng_run, 1'b1);
    wr_reg(A_ENG, 32'h0000_0000);
    settle();
    chk_bit(eng_run, 1'b0);
    // Program location boundaries, back to back.
    wr_reg(A_LOC, 32'h0000_0000);
    settle();
    chk({15'h0, eng_base}, 32'h0000_0000);
    wr_reg(A_LOC, 32'h0000_007f, 1'b1);
    rd(A_LOC, 32'h0000_007f, 32'h0000_007f);
    chk({15'h0, eng_base}, 32'h0001_fc00);
    wr_reg(A_LOC, 32'h0000_008a);
    settle();
    chk({15'h0, eng_base}, 32'h0000_2800);
    $display("test engine done");
    // Battery result follows the input and ignores writes.
    batt_in <= 8'ha5;
    repeat (4) settle();
    rd(A_RES, 32'h0000_00ff, 32'h0000_00a5);
    wr_reg(A_RES, 32'h0000_005a);
    rd(A_RES, 32'h0000_00ff, 32'h0000_00a5);
    batt_in <= 8'h3c;
    repeat (4) settle();
    rd(A_RES, 32'h0000_00ff, 32'h0000_003c);
    // Unmapped read answers zero with an error.
    apb(1'b0, 16'h0000, 32'h0000_0000, 4'h0, 1'b0, rv, ev);
    chk(rv, 32'h0000_0000);
    chk_bit(ev, 1'b1);
    $display("test battery done");
    // A second reset in mid-run restores the output levels, the location and the analogue word.
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) settle();
    chk_reset_outs();
    @(posedge pclk);
    presetn <= 1'b1;
    rd(A_LOC, 32'h0000_007f, 32'h0000_001f);
    rd(A_ANA, 32'h0000_0018, 32'h0000_0000);
    $display("test second reset done");
    stop_test();
  end
endmodule
